/* rsi_pkg.sv */
`default_nettype none
package rsi_pkg;
   // Core clock and derived cycle counts
   localparam int RSI_CLK_KHZ = 40000;
   localparam int RSI_STAB_TIME_MS = 250;
   localparam int RSI_STAB_CYCLES = RSI_STAB_TIME_MS * RSI_CLK_KHZ;
   localparam int RSI_WDT_PULSE_US = 20;
   localparam int RSI_WDT_PULSE_CYCLES = (RSI_WDT_PULSE_US * RSI_CLK_KHZ) / 1000;
   localparam int RSI_TMR_W = 24;

   // Setting register indices
   localparam int RSI_NREG = 51;
   localparam int RSI_IDX_W = 6;
   localparam logic [5:0] RSI_PROC_CLK = 6'h00, RSI_MEM_SIZE = 6'h01, RSI_XRAM_SIZE = 6'h02,
      RSI_WDT_MODE = 6'h03, RSI_WDT_CLK = 6'h04,
      RSI_SMP_CNT_A = 6'h05, RSI_SMP_CNT_B = 6'h06, RSI_SMP_CMP_A = 6'h07, RSI_SMP_CMP_B = 6'h08,
      RSI_SMP_CSEL_A = 6'h09, RSI_SMP_CSEL_B = 6'h0a, RSI_SMP_CTRL = 6'h0b,
      RSI_SMP_LEVEL = 6'h0c, RSI_SMP_PIN = 6'h0d,
      RSI_MR_CNT = 6'h0e, RSI_MR_CMP = 6'h0f, RSI_MR_CTRL = 6'h10, RSI_MR_OUT = 6'h11,
      RSI_MR_SMP = 6'h12,
      RSI_AS_MODE = 6'h13, RSI_AS_FUNC = 6'h14, RSI_AS_STAT = 6'h15, RSI_AS_BAUD = 6'h16,
      RSI_AS_PINSW = 6'h17, RSI_AS_TX = 6'h18, RSI_AS_RX = 6'h19,
      RSI_CS_SHIFT = 6'h1a, RSI_CS_MODE = 6'h1b,
      RSI_RT_DATA0 = 6'h1c, RSI_RT_DATA1 = 6'h1d, RSI_RT_RELOAD = 6'h1e, RSI_RT_MODE = 6'h1f,
      RSI_LCD_MODE = 6'h20, RSI_LCD_CLK = 6'h21, RSI_PFC7 = 6'h22, RSI_PFC8 = 6'h23,
      RSI_PFC9 = 6'h24,
      RSI_IRQ_REQ0 = 6'h25, RSI_IRQ_MASK0 = 6'h29, RSI_IRQ_PRIO0 = 6'h2d, RSI_IRQ_LAST = 6'h30,
      RSI_EDGE_RISE = 6'h31, RSI_EDGE_FALL = 6'h32;

   // Values after reset and recommended settings
   localparam logic [7:0] RSI_CLR_RST = 8'h00;
   localparam logic [7:0] RSI_PROC_CLK_RST = 8'h04;
   localparam logic [7:0] RSI_PROC_CLK_MAX = 8'h02;
   localparam logic [7:0] RSI_MEM_SIZE_RST = 8'hcf;
   localparam logic [7:0] RSI_MEM_SIZE_48K = 8'hcc;
   localparam logic [7:0] RSI_XRAM_RST = 8'h0c;
   localparam logic [7:0] RSI_XRAM_USE = 8'h0a;
   localparam logic [7:0] RSI_TX_RST = 8'hff;
   localparam logic [7:0] RSI_MASK_RST = 8'hff;
   localparam logic [15:0] RSI_ROM60_END = 16'hefff;
   localparam logic [15:0] RSI_ROM48_END = 16'hbfff;

   typedef logic [RSI_NREG-1:0][7:0] rsi_regs_t;

   typedef enum logic [1:0] {
      RSI_RUN = 2'b00,
      RSI_HOLD = 2'b01,
      RSI_WAIT = 2'b10
   } rsi_phase_t;

   // Contents left alone by reset
   function automatic logic rsi_undef(input logic [5:0] idx);
      return (idx == RSI_AS_RX) || (idx == RSI_CS_SHIFT);
   endfunction

   function automatic logic [7:0] rsi_rst_val(input logic [5:0] idx);
      logic [7:0] v;
      v = RSI_CLR_RST;
      if (idx == RSI_PROC_CLK) v = RSI_PROC_CLK_RST;
      else if (idx == RSI_MEM_SIZE) v = RSI_MEM_SIZE_RST;
      else if (idx == RSI_XRAM_SIZE) v = RSI_XRAM_RST;
      else if (idx == RSI_AS_TX) v = RSI_TX_RST;
      else if (idx >= RSI_IRQ_MASK0 && idx <= RSI_IRQ_LAST) v = RSI_MASK_RST;
      return v;
   endfunction

   function automatic rsi_regs_t rsi_rst_table();
      rsi_regs_t t;
      for (int i = 0; i < RSI_NREG; i++) begin
         t[i] = rsi_rst_val(6'(i));
      end
      return t;
   endfunction

   localparam rsi_regs_t RSI_REGS_RST = rsi_rst_table();
endpackage
`default_nettype wire

/* rsi_tmr_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface rsi_tmr_if;
   logic start;
   logic [rsi_pkg::RSI_TMR_W-1:0] count;
   logic busy;
   logic done;
   modport ctl (output start, output count, input busy, input done);
   modport tmr (input start, input count, output busy, output done);
endinterface
`default_nettype wire

/* rsi_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module rsi_timer
   import rsi_pkg::*;
(
   input wire logic clk,   // Core clock
   input wire logic rst_n, // Synchronous reset, low
   rsi_tmr_if.tmr t        // Start/busy/done link
);
   typedef struct packed {
      logic busy;
      logic [RSI_TMR_W-1:0] left;
   } rsi_tmr_st_t;

   rsi_tmr_st_t st;
   rsi_tmr_st_t next_st;

   // Busy for exactly count cycles, one cycle for a zero count; done marks the last one
   always_comb begin
      next_st = st;
      if (t.start) begin
         next_st.busy = 1'b1;
         next_st.left = (t.count == '0) ? '0 : t.count - 1'b1;
      end else if (st.busy) begin
         if (st.left == '0) begin
            next_st.busy = 1'b0;
         end else begin
            next_st.left = st.left - 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign t.busy = st.busy;
   assign t.done = st.busy && (st.left == '0);
endmodule // rsi_timer
`default_nettype wire

/* rsi_reset_init.sv */
// What this block does
// - Program counter invalid during reset and stabilization wait; everything else already reset.
// - Reset arriving in standby keeps data memory and register bank contents.
// - Memory size select resets to CFH; software writes CCH for smaller ROM.
// - Expansion RAM size select resets to 0CH; software then writes 0AH.
// - Reset clears watchdog mode and watchdog clock select to 00H.
// - Reset clears all sampling timer/detector settings, counters and status to 00H.
// - Reset clears MR counter, compare, control, output and sampling control to 00H.
// - Reset clears async serial settings, loads transmit shifter FFH, receive buffer undefined.
// - Reset clears clocked serial mode; clocked serial shifter left undefined.
// - Reset clears real-time output data, reload compare and mode to 00H.
// - Reset clears LCD display mode, LCD clock and port 7-9 functions to 00H.
// - Reset clears request flags, sets mask and priority flags to FFH.
// - Reset clears rising and falling edge enables to 00H.
// - After watchdog reset, overflow output pulses 20 us: high flash, low otherwise.
// - Program memory is 60 KB, reducible to 48 KB via memory size select.
// - Watchdog overflow resets internally, releases after stabilization, signals overflow pin.
`timescale 1ns/1ps
`default_nettype none
module rsi_reset_init
   import rsi_pkg::*;
#(
   parameter int STAB_CYCLES = RSI_STAB_CYCLES, // Oscillation stabilization wait
   parameter bit FLASH_VARIANT = 1'b1            // Selects overflow pulse polarity
) (
   input wire logic clk,                 // Core clock, 40 MHz
   input wire logic rst_n,               // Synchronous reset, low
   input wire logic reset_pin_n,         // External reset pin, asynchronous
   input wire logic wdt_overflow,        // Watchdog overflow pulse
   input wire logic standby,             // Core is in a standby mode
   input wire logic cfg_we,              // Setting write strobe
   input wire logic [5:0] cfg_sel,       // Setting index
   input wire logic [7:0] cfg_wdata,     // Setting write data
   output logic [7:0] cfg_rdata,         // Setting read data, one cycle later
   output logic hw_reset,                // Hardware held in reset state
   output logic pc_valid,                // Program counter may be used
   output logic pins_hiz,                // Pins float during reset
   output logic ram_retain,              // Memory contents kept over last reset
   output logic watchdog_overflow_out,   // Watchdog overflow pin
   output logic [15:0] rom_end_addr,     // Last usable program address
   output logic mem_size_ok,             // Memory size select holds a legal value
   output logic xram_size_ok,            // Expansion RAM size select is 0AH
   output logic proc_clk_ok              // Processor clock control is usable
);
   typedef struct packed {
      rsi_phase_t phase;
      logic pin_meta;
      logic pin_sync;
      logic ram_retain;
      rsi_regs_t regs;
      logic [7:0] rdata;
      logic [15:0] rom_end;
      logic mem_ok;
      logic xram_ok;
      logic pclk_ok;
   } rsi_st_t;

   localparam rsi_st_t RSI_ST_RST = '{
      phase: RSI_HOLD,
      pin_meta: 1'b0,
      pin_sync: 1'b0,
      ram_retain: 1'b0,
      regs: RSI_REGS_RST,
      rdata: 8'h00,
      rom_end: RSI_ROM60_END,
      mem_ok: 1'b1,
      xram_ok: 1'b0,
      pclk_ok: 1'b0
   };

   rsi_st_t st;
   rsi_st_t next_st;
   logic pin_low;
   logic wdt_trip;
   logic reset_entry;

   rsi_tmr_if stab_if ();
   rsi_tmr_if pulse_if ();

   rsi_timer u_stab (
      .clk(clk),
      .rst_n(rst_n),
      .t(stab_if)
   );

   rsi_timer u_pulse (
      .clk(clk),
      .rst_n(rst_n),
      .t(pulse_if)
   );

   assign pin_low = !st.pin_sync;
   assign wdt_trip = (st.phase == RSI_RUN) && wdt_overflow && !pin_low;

   always_comb begin
      next_st = st;
      next_st.pin_meta = reset_pin_n;
      next_st.pin_sync = st.pin_meta;
      case (st.phase)
         RSI_RUN: begin
            if (pin_low) begin
               next_st.phase = RSI_HOLD;
            end else if (wdt_overflow) begin
               // Internal reset needs no release, goes straight to the wait
               next_st.phase = RSI_WAIT;
            end
         end
         RSI_HOLD: begin
            if (!pin_low) begin
               next_st.phase = RSI_WAIT;
            end
         end
         RSI_WAIT: begin
            // Pin asserted again restarts the whole sequence
            if (pin_low) begin
               next_st.phase = RSI_HOLD;
            end else if (stab_if.done) begin
               next_st.phase = RSI_RUN;
            end
         end
         default: begin
            next_st.phase = RSI_HOLD;
         end
      endcase

      // Standby decides whether memory survives this reset
      if (st.phase == RSI_RUN && next_st.phase != RSI_RUN) begin
         next_st.ram_retain = standby;
      end

      // Reset table stays loaded for the whole reset and wait
      if (st.phase != RSI_RUN || next_st.phase != RSI_RUN) begin
         for (int i = 0; i < RSI_NREG; i++) begin
            if (!rsi_undef(6'(i))) begin
               next_st.regs[i] = rsi_rst_val(6'(i));
            end
         end
      end else if (cfg_we && cfg_sel < 6'(RSI_NREG)) begin
         next_st.regs[cfg_sel] = cfg_wdata;
      end

      next_st.rdata = (cfg_sel < 6'(RSI_NREG)) ? st.regs[cfg_sel] : 8'h00;
      // Only CCH narrows the map; CFH and illegal codes keep full size
      next_st.rom_end = (next_st.regs[RSI_MEM_SIZE] == RSI_MEM_SIZE_48K) ?
         RSI_ROM48_END : RSI_ROM60_END;
      next_st.mem_ok = (next_st.regs[RSI_MEM_SIZE] == RSI_MEM_SIZE_RST) ||
         (next_st.regs[RSI_MEM_SIZE] == RSI_MEM_SIZE_48K);
      next_st.xram_ok = (next_st.regs[RSI_XRAM_SIZE] == RSI_XRAM_USE);
      next_st.pclk_ok = (next_st.regs[RSI_PROC_CLK] <= RSI_PROC_CLK_MAX);
   end

   assign reset_entry = (st.phase == RSI_RUN) && (next_st.phase != RSI_RUN);

   // Wait timer restarts on every entry into the wait
   assign stab_if.start = (next_st.phase == RSI_WAIT) && (st.phase != RSI_WAIT);
   assign stab_if.count = RSI_TMR_W'(STAB_CYCLES);
   assign pulse_if.start = wdt_trip;
   assign pulse_if.count = RSI_TMR_W'(RSI_WDT_PULSE_CYCLES);

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st <= RSI_ST_RST;
      end else begin
         st <= next_st;
      end
   end

   assign pc_valid = (st.phase == RSI_RUN);
   assign hw_reset = !pc_valid;
   assign pins_hiz = !pc_valid;
   assign cfg_rdata = st.rdata;
   assign ram_retain = st.ram_retain;
   assign rom_end_addr = st.rom_end;
   assign mem_size_ok = st.mem_ok;
   assign xram_size_ok = st.xram_ok;
   assign proc_clk_ok = st.pclk_ok;
   // Polarity differs between flash and mask parts
   assign watchdog_overflow_out = FLASH_VARIANT ? pulse_if.busy : !pulse_if.busy;

   // Checks

   function automatic logic regs_at_reset(input rsi_regs_t r);
      logic ok;
      ok = 1'b1;
      for (int i = 0; i < RSI_NREG; i++) begin
         if (!rsi_undef(6'(i)) && r[i] != rsi_rst_val(6'(i))) begin
            ok = 1'b0;
         end
      end
      return ok;
   endfunction

   int wait_cnt;

   always_ff @(posedge clk) begin
      if (!rst_n || st.phase != RSI_WAIT) begin
         wait_cnt <= 0;
      end else begin
         wait_cnt <= wait_cnt + 1;
      end
   end

   // Counted apart from the timer so a timer fault still shows
   int pulse_cnt;

   always_ff @(posedge clk) begin
      if (!rst_n || wdt_trip) begin
         pulse_cnt <= 0;
      end else if (pulse_if.busy) begin
         pulse_cnt <= pulse_cnt + 1;
      end
   end

   default clocking dc @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   sequence held_s;
      !pc_valid ##1 !pc_valid;
   endsequence

   sequence wdt_trip_s;
      (st.phase == RSI_RUN) && wdt_overflow && st.pin_sync;
   endsequence

   table_load_a: assert property (
      held_s |-> regs_at_reset(st.regs))
      else $error("reset table not held during reset");

   pc_hold_a: assert property (
      held_s |-> hw_reset && pins_hiz && st.regs[RSI_PROC_CLK] == RSI_PROC_CLK_RST)
      else $error("state not reset while program counter invalid");

   mem_size_rst_a: assert property (
      held_s |-> st.regs[RSI_MEM_SIZE] == RSI_MEM_SIZE_RST && mem_size_ok)
      else $error("memory size select not at reset value");

   xram_rst_a: assert property (
      held_s |-> st.regs[RSI_XRAM_SIZE] == RSI_XRAM_RST && !xram_size_ok)
      else $error("expansion ram size select not at reset value");

   wdt_clear_a: assert property (
      held_s |-> st.regs[RSI_WDT_MODE] == 8'h00 && st.regs[RSI_WDT_CLK] == 8'h00)
      else $error("watchdog settings not cleared");

   irq_masked_a: assert property (
      held_s |-> st.regs[RSI_IRQ_MASK0] == 8'hff && st.regs[RSI_IRQ_PRIO0] == 8'hff
         && st.regs[RSI_IRQ_LAST] == 8'hff && st.regs[RSI_IRQ_REQ0] == 8'h00)
      else $error("interrupt flags not at reset values");

   ram_keep_a: assert property (
      reset_entry |=> ram_retain == $past(standby))
      else $error("memory retention does not follow standby");

   wdt_pulse_a: assert property (
      wdt_trip_s |=> (watchdog_overflow_out == FLASH_VARIANT) [*8])
      else $error("watchdog overflow pulse wrong level");

   wdt_release_a: assert property (
      wdt_trip_s |=> !pc_valid ##1 (!pc_valid && stab_if.busy))
      else $error("watchdog overflow did not start reset wait");

   wait_len_a: assert property (
      $rose(pc_valid) |-> wait_cnt == STAB_CYCLES)
      else $error("stabilization wait has wrong length");

   rom_map_a: assert property (
      st.regs[RSI_MEM_SIZE] == RSI_MEM_SIZE_48K |-> rom_end_addr == RSI_ROM48_END)
      else $error("rom end not reduced for small map");

   pulse_len_a: assert property (
      $fell(pulse_if.busy) |-> pulse_cnt == RSI_WDT_PULSE_CYCLES)
      else $error("watchdog overflow pulse has wrong length");

   ram_hold_a: assert property (
      !reset_entry |=> $stable(ram_retain))
      else $error("memory retention changed outside reset entry");

   pin_entry_a: assert property (
      pc_valid && pin_low |=> hw_reset && pins_hiz)
      else $error("reset pin did not stop the program counter");

   tx_preset_a: assert property (
      held_s |-> st.regs[RSI_AS_TX] == RSI_TX_RST && st.regs[RSI_AS_MODE] == 8'h00)
      else $error("async serial settings not at reset values");

   undef_keep_a: assert property (
      reset_entry |=> st.regs[RSI_AS_RX] == $past(st.regs[RSI_AS_RX])
         && st.regs[RSI_CS_SHIFT] == $past(st.regs[RSI_CS_SHIFT]))
      else $error("undefined-after-reset contents were touched");

   wait_cap_a: assert property (
      wait_cnt <= STAB_CYCLES)
      else $error("stabilization wait overran");

   lcd_clear_a: assert property (
      held_s |-> st.regs[RSI_LCD_MODE] == 8'h00 && st.regs[RSI_LCD_CLK] == 8'h00
         && st.regs[RSI_PFC7] == 8'h00 && st.regs[RSI_PFC9] == 8'h00)
      else $error("lcd and port function settings not cleared");

   rom_full_a: assert property (
      st.regs[RSI_MEM_SIZE] != RSI_MEM_SIZE_48K |-> rom_end_addr == RSI_ROM60_END)
      else $error("rom end reduced without small map code");

   edge_clear_a: assert property (
      held_s |-> st.regs[RSI_EDGE_RISE] == 8'h00 && st.regs[RSI_EDGE_FALL] == 8'h00)
      else $error("edge enables not cleared");
endmodule // rsi_reset_init
`default_nettype wire

/* rsi_reset_init_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module rsi_reset_init_tb;
   import rsi_pkg::*;
   localparam int STAB = 20;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic reset_pin_n = 1'b1;
   logic wdt_overflow = 1'b0;
   logic standby = 1'b0;
   logic cfg_we = 1'b0;
   logic [5:0] cfg_sel = 6'h00;
   logic [7:0] cfg_wdata = 8'h00;
   logic [7:0] cfg_rdata;
   logic hw_reset, pc_valid, pins_hiz, ram_retain, watchdog_overflow_out;
   logic [15:0] rom_end_addr;
   logic mem_size_ok, xram_size_ok, proc_clk_ok;
   logic wdt_out_mask;
   int fails = 0;
   int comparisons = 0;
   int cycles = 0;

   rsi_reset_init #(.STAB_CYCLES(STAB), .FLASH_VARIANT(1'b1)) rsi_reset_init_inst (
      .clk(clk), .rst_n(rst_n), .reset_pin_n(reset_pin_n), .wdt_overflow(wdt_overflow),
      .standby(standby), .cfg_we(cfg_we), .cfg_sel(cfg_sel), .cfg_wdata(cfg_wdata),
      .cfg_rdata(cfg_rdata), .hw_reset(hw_reset), .pc_valid(pc_valid), .pins_hiz(pins_hiz),
      .ram_retain(ram_retain), .watchdog_overflow_out(watchdog_overflow_out),
      .rom_end_addr(rom_end_addr), .mem_size_ok(mem_size_ok), .xram_size_ok(xram_size_ok),
      .proc_clk_ok(proc_clk_ok));

   // Mask part on the same inputs, only its overflow pin is watched
   if (1) begin : mask_part
      rsi_reset_init #(.STAB_CYCLES(STAB), .FLASH_VARIANT(1'b0)) rsi_reset_init_inst (
         .clk(clk), .rst_n(rst_n), .reset_pin_n(reset_pin_n), .wdt_overflow(wdt_overflow),
         .standby(standby), .cfg_we(cfg_we), .cfg_sel(cfg_sel), .cfg_wdata(cfg_wdata),
         .cfg_rdata(), .hw_reset(), .pc_valid(), .pins_hiz(), .ram_retain(),
         .watchdog_overflow_out(wdt_out_mask), .rom_end_addr(), .mem_size_ok(),
         .xram_size_ok(), .proc_clk_ok());
   end

   always #12.5 clk = ~clk;

   // Whole run needs well under 10k cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         end_sim();
      end
   end

   task automatic end_sim();
      $display("comparisons=%0d fails=%0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic tick();
      @(posedge clk);
      #1;
   endtask

   task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Strobe dropped with an idle edge after, so back-to-back calls never clash
   task automatic wr(input logic [5:0] s, input logic [7:0] d);
      cfg_we = 1'b1;
      cfg_sel = s;
      cfg_wdata = d;
      tick();
      cfg_we = 1'b0;
      tick();
   endtask

   task automatic rd(input logic [5:0] s, output logic [7:0] d);
      cfg_sel = s;
      tick();
      tick();
      d = cfg_rdata;
   endtask

   task automatic wait_run(output int n);
      n = 0;
      while (pc_valid !== 1'b1 && n < 200) begin
         tick();
         n++;
      end
   endtask

   function automatic logic [7:0] exp_rst(input int i);
      if (i == RSI_PROC_CLK) return 8'h04;
      if (i == RSI_MEM_SIZE) return 8'hcf;
      if (i == RSI_XRAM_SIZE) return 8'h0c;
      if (i == RSI_AS_TX) return 8'hff;
      if (i >= RSI_IRQ_MASK0 && i <= RSI_IRQ_LAST) return 8'hff;
      return 8'h00;
   endfunction

   function automatic logic [7:0] pat(input int i);
      return 8'(i) ^ 8'h5a;
   endfunction

   // Untouched entries must still hold the pattern when keep is set
   task automatic check_table(input bit keep);
      logic [7:0] v;
      for (int i = 0; i < RSI_NREG; i++) begin
         rd(6'(i), v);
         if (i == RSI_AS_RX || i == RSI_CS_SHIFT) begin
            if (keep) chk_val({8'h00, v}, {8'h00, pat(i)});
         end else begin
            chk_val({8'h00, v}, {8'h00, exp_rst(i)});
         end
      end
   endtask

   task automatic t_por();
      int n;
      repeat (8) tick();
      chk_bit(hw_reset, 1'b1);
      chk_bit(pins_hiz, 1'b1);
      chk_bit(pc_valid, 1'b0);
      chk_bit(ram_retain, 1'b0);
      chk_bit(watchdog_overflow_out, 1'b0);
      chk_bit(wdt_out_mask, 1'b1);
      chk_val(rom_end_addr, 16'hefff);
      chk_bit(mem_size_ok, 1'b1);
      chk_bit(xram_size_ok, 1'b0);
      chk_bit(proc_clk_ok, 1'b0);
      rst_n = 1'b1;
      wait_run(n);
      chk_bit(n >= STAB && n <= STAB + 4, 1'b1);
      chk_bit(hw_reset, 1'b0);
      check_table(1'b0);
   endtask

   task automatic t_cfg();
      logic [7:0] v;
      wr(RSI_MEM_SIZE, 8'hcc);
      chk_val(rom_end_addr, 16'hbfff);
      chk_bit(mem_size_ok, 1'b1);
      wr(RSI_MEM_SIZE, 8'hab);
      chk_bit(mem_size_ok, 1'b0);
      chk_val(rom_end_addr, 16'hefff);
      wr(RSI_MEM_SIZE, 8'hcf);
      chk_val(rom_end_addr, 16'hefff);
      wr(RSI_XRAM_SIZE, 8'h0a);
      chk_bit(xram_size_ok, 1'b1);
      wr(RSI_XRAM_SIZE, 8'h0c);
      chk_bit(xram_size_ok, 1'b0);
      for (int k = 0; k < 5; k++) begin
         wr(RSI_PROC_CLK, 8'(k));
         chk_bit(proc_clk_ok, k <= 2);
      end
      wr(6'h33, 8'ha5);
      rd(6'h33, v);
      chk_val({8'h00, v}, 16'h0000);
      for (int i = 0; i < RSI_NREG; i++) wr(6'(i), pat(i));
      rd(RSI_IRQ_MASK0, v);
      chk_val({8'h00, v}, {8'h00, pat(RSI_IRQ_MASK0)});
   endtask

   task automatic t_pin();
      int n;
      standby = 1'b1;
      reset_pin_n = 1'b0;
      n = 0;
      while (hw_reset !== 1'b1 && n < 6) begin
         tick();
         n++;
      end
      chk_bit(n <= 3, 1'b1);
      standby = 1'b0;
      wdt_overflow = 1'b1;
      tick();
      wdt_overflow = 1'b0;
      // Write in hold must be dropped; table check reads the reset value back
      wr(RSI_PROC_CLK, 8'h02);
      chk_bit(watchdog_overflow_out, 1'b0);
      chk_bit(wdt_out_mask, 1'b1);
      chk_bit(pc_valid, 1'b0);
      chk_bit(pins_hiz, 1'b1);
      chk_bit(ram_retain, 1'b1);
      reset_pin_n = 1'b1;
      wait_run(n);
      chk_bit(n >= STAB && n <= STAB + 4, 1'b1);
      chk_bit(ram_retain, 1'b1);
      check_table(1'b1);
   endtask

   task automatic t_wdt();
      int n;
      int k;
      int run_at;
      logic [7:0] v;
      wr(RSI_PROC_CLK, 8'h01);
      wdt_overflow = 1'b1;
      tick();
      wdt_overflow = 1'b0;
      n = 0;
      while (hw_reset !== 1'b1 && n < 3) begin
         tick();
         n++;
      end
      chk_bit(hw_reset, 1'b1);
      chk_bit(watchdog_overflow_out, 1'b1);
      chk_bit(wdt_out_mask, 1'b0);
      k = 0;
      run_at = 0;
      while (watchdog_overflow_out === 1'b1 && k < 2000) begin
         tick();
         k++;
         if (pc_valid === 1'b1 && run_at == 0) run_at = k;
      end
      chk_val(16'(k), 16'(RSI_WDT_PULSE_CYCLES));
      chk_bit(wdt_out_mask, 1'b1);
      chk_bit(run_at >= STAB - 1 && run_at <= STAB + 4, 1'b1);
      chk_bit(ram_retain, 1'b0);
      rd(RSI_PROC_CLK, v);
      chk_val({8'h00, v}, 16'h0004);
   endtask

   initial begin
      t_por();
      t_cfg();
      t_pin();
      t_wdt();
      end_sim();
   end
endmodule // rsi_reset_init_tb
`default_nettype wire
